//--- core/sar_adc_pkg.sv
// shared constants and types of the converter control block
// assumes a 32-bit classic wishbone master and a 50 MHz clk_i
package sar_adc_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SEL_OFS = 8'h04;
  localparam logic [7:0] LOW_OFS = 8'h08;
  localparam logic [7:0] HIGH_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  // control register fields
  localparam int EN_BIT = 7;
  localparam int START_BIT = 6;
  localparam int FREE_BIT = 5;
  localparam int DONE_BIT = 4;
  localparam int DIV_LSB = 0;
  // select register fields
  localparam int CH_LSB = 0;
  localparam int LEFT_BIT = 5;
  localparam int REF_LSB = 6;
  // status register fields
  localparam int BUSY_BIT = 0;
  localparam int FIRST_BIT = 1;
  localparam int LOCK_BIT = 2;
  // widths
  localparam int RES_W = 10;
  localparam int CH_W = 5;
  localparam int REF_W = 2;
  localparam int DIV_W = 3;
  localparam int CNT_W = 5;
  localparam int PRE_W = 7;
  localparam int LEFT_PAD = 6;
  // converter clock cycle counts
  localparam logic [CNT_W-1:0] NORMAL_LEN = 5'h0d;
  localparam logic [CNT_W-1:0] DIFF_LEN = 5'h0e;
  localparam logic [CNT_W-1:0] EXT_LEN = 5'h19;
  localparam logic [CNT_W-1:0] SAMPLE_NORMAL = 5'h01;
  localparam logic [CNT_W-1:0] SAMPLE_DIFF = 5'h02;
  localparam logic [CNT_W-1:0] SAMPLE_EXT = 5'h0d;
  // channel codes that route through the gain stage
  localparam logic [CH_W-1:0] DIFF_FIRST = 5'h08;
  localparam logic [CH_W-1:0] DIFF_LAST = 5'h1d;
  // prescaler
  localparam logic [DIV_W-1:0] DIV_MIN_SEL = 3'h0;
  localparam logic [PRE_W-1:0] DIV_MIN_TOP = 7'h01;
  localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;

  typedef enum logic {S_IDLE, S_CONVERT} conv_state_e;

  // everything the analog side needs, all from flops
  typedef struct packed {
    logic enable;
    logic [CH_W-1:0] channel;
    logic [REF_W-1:0] reference;
    logic gain_bypass;
    logic sample;
  } conv_ctrl_s;
endpackage

//--- core/sel_buffer.sv
// temporary buffer for a selection field
// assumes load_i is synchronous to clk_i
`timescale 1ns/1ps
module sel_buffer #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // update path
  input wire logic load_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] q;
  } buf_state_s;

  buf_state_s s_q;
  buf_state_s s_d;

  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d.q = d_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.q;
endmodule // sel_buffer

//--- core/conv_prescaler.sv
// converter clock prescaler: rise and fall enables of the divided clock
// assumes enable_i and div_sel_i come from logic on clk_i
`timescale 1ns/1ps
module conv_prescaler (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic enable_i,
  input wire logic [sar_adc_pkg::DIV_W-1:0] div_sel_i,
  // divided clock events
  output logic rise_o,
  output logic fall_o,
  output logic half_rate_o
);
  typedef struct packed {
    logic [sar_adc_pkg::PRE_W-1:0] cnt;
    logic rise;
    logic fall;
    logic half;
  } pre_state_s;

  pre_state_s s_q;
  pre_state_s s_d;
  logic [sar_adc_pkg::PRE_W-1:0] top;

  always_comb begin
    s_d = s_q;
    top = sar_adc_pkg::DIV_MIN_TOP;
    if (div_sel_i != sar_adc_pkg::DIV_MIN_SEL) begin
      top = (sar_adc_pkg::PRE_ONE << div_sel_i) - sar_adc_pkg::PRE_ONE;
    end
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    // held in reset for as long as the converter is off
    if (!enable_i) begin
      s_d = '0;
    end else begin
      s_d.cnt = s_q.cnt + sar_adc_pkg::PRE_ONE;
      if (s_q.cnt == top) begin
        s_d.cnt = '0;
        s_d.rise = 1'b1;
        s_d.half = !s_q.half;
      end
      if (s_q.cnt == (top >> 1)) begin
        s_d.fall = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise_o = s_q.rise;
  assign fall_o = s_q.fall;
  assign half_rate_o = s_q.half;
endmodule // conv_prescaler

//--- core/sar_adc_ctrl.sv
// control of a 10-bit successive approximation converter behind wishbone
// assumes the analog core is clocked logic on clk_i whose result_i is
// settled by the end of the conversion
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
// Notes on behaviour
// - 10-bit result, right adjusted unless left alignment bit set.
// - after a low read, results are dropped until the high read.
// - reading the high half unlocks the result halves again.
// - completion flag still rises when a result is dropped.
// - writing start begins a conversion; bit stays high until done.
// - a channel change mid conversion applies only afterwards.
// - free running set by its bit; first conversion started by software.
// - free running restarts at once, start bit high, flag ignored.
// - enable bit gates all activity and selection updates.
// - prescaler counts only while enabled, held reset otherwise.
// - a requested conversion begins on the next converter clock rise.
// - sample 1.5 cycles after start, 2.5 in a 14-cycle one, 13.5 on the first after enabling.
// - completion stores result unless locked, sets flag, clears start in single mode.
// - 13 cycles normal, 14 some differential, 25 extended first.
// - channel select picks input and gain; single-ended bypasses gain.
// - reference select chooses the conversion reference.
// - selection buffer frozen during conversion, reopened in last cycle.
// - differential takes 14 cycles if started high or auto started.
module sar_adc_ctrl (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // analog core
  output sar_adc_pkg::conv_ctrl_s conv_o,
  input wire logic [sar_adc_pkg::RES_W-1:0] result_i,
  output logic conversion_done_o
);
  typedef struct packed {
    sar_adc_pkg::conv_state_e state;
    logic enable;
    logic start;
    logic free;
    logic flag;
    logic [sar_adc_pkg::DIV_W-1:0] div;
    logic [sar_adc_pkg::CH_W-1:0] channel;
    logic left;
    logic [sar_adc_pkg::REF_W-1:0] reference;
    logic [sar_adc_pkg::RES_W-1:0] result;
    logic lock;
    logic first;
    logic ext;
    logic frozen;
    logic [sar_adc_pkg::CNT_W-1:0] cyc;
    logic [sar_adc_pkg::CNT_W-1:0] len;
    logic [sar_adc_pkg::CNT_W-1:0] sample_at;
    logic sample;
    logic done;
    logic ack;
    logic [31:0] rdata;
  } ctrl_state_s;

  ctrl_state_s s_q;
  ctrl_state_s s_d;
  logic rise;
  logic fall;
  logic half_rate;
  logic bus_acc;
  logic complete;
  logic buf_load;
  logic reg_bypass;
  logic conv_diff;
  logic [sar_adc_pkg::CH_W-1:0] channel_q;
  logic bypass_q;
  logic [sar_adc_pkg::REF_W-1:0] reference_q;
  logic [7:0] res_low;
  logic [7:0] res_high;

  conv_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(s_q.enable),
    .div_sel_i(s_q.div),
    .rise_o(rise),
    .fall_o(fall),
    .half_rate_o(half_rate)
  );

  // selections only reach the core while enabled and not frozen
  assign buf_load = s_q.enable && !s_q.frozen;
  assign reg_bypass = (s_q.channel < sar_adc_pkg::DIFF_FIRST) ||
    (s_q.channel > sar_adc_pkg::DIFF_LAST);
  assign conv_diff = !bypass_q;

  sel_buffer #(.W(sar_adc_pkg::CH_W + 1)) u_chan_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(buf_load),
    .d_i({reg_bypass, s_q.channel}),
    .q_o({bypass_q, channel_q})
  );

  sel_buffer #(.W(sar_adc_pkg::REF_W)) u_ref_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(buf_load),
    .d_i(s_q.reference),
    .q_o(reference_q)
  );

  // alignment is applied at read time, so the stored word stays 10 bits
  always_comb begin
    if (s_q.left) begin
      res_high = s_q.result[sar_adc_pkg::RES_W-1:2];
      res_low = {s_q.result[1:0], {sar_adc_pkg::LEFT_PAD{1'b0}}};
    end else begin
      res_high = {{sar_adc_pkg::LEFT_PAD{1'b0}}, s_q.result[sar_adc_pkg::RES_W-1:8]};
      res_low = s_q.result[7:0];
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.sample = 1'b0;
    s_d.done = 1'b0;
    s_d.ack = 1'b0;
    complete = 1'b0;
    bus_acc = wb_cyc_i && wb_stb_i && !s_q.ack;
    // register access; every address answers, unmapped reads give zero
    if (bus_acc) begin
      s_d.ack = 1'b1;
      s_d.rdata = '0;
      if (wb_we_i) begin
        if (wb_adr_i == sar_adc_pkg::CTRL_OFS && wb_sel_i[0]) begin
          s_d.enable = wb_dat_i[sar_adc_pkg::EN_BIT];
          s_d.free = wb_dat_i[sar_adc_pkg::FREE_BIT];
          s_d.div = wb_dat_i[sar_adc_pkg::DIV_LSB +: sar_adc_pkg::DIV_W];
          if (wb_dat_i[sar_adc_pkg::START_BIT] && wb_dat_i[sar_adc_pkg::EN_BIT]) begin
            s_d.start = 1'b1;
          end
          if (wb_dat_i[sar_adc_pkg::DONE_BIT]) begin
            s_d.flag = 1'b0;
          end
          if (!wb_dat_i[sar_adc_pkg::EN_BIT]) begin
            s_d.state = sar_adc_pkg::S_IDLE;
            s_d.start = 1'b0;
            s_d.frozen = 1'b0;
            s_d.first = 1'b1;
          end
        end else if (wb_adr_i == sar_adc_pkg::SEL_OFS && wb_sel_i[0]) begin
          s_d.channel = wb_dat_i[sar_adc_pkg::CH_LSB +: sar_adc_pkg::CH_W];
          s_d.left = wb_dat_i[sar_adc_pkg::LEFT_BIT];
          s_d.reference = wb_dat_i[sar_adc_pkg::REF_LSB +: sar_adc_pkg::REF_W];
        end
      end else begin
        if (wb_adr_i == sar_adc_pkg::CTRL_OFS) begin
          s_d.rdata[sar_adc_pkg::EN_BIT] = s_q.enable;
          s_d.rdata[sar_adc_pkg::START_BIT] = s_q.start;
          s_d.rdata[sar_adc_pkg::FREE_BIT] = s_q.free;
          s_d.rdata[sar_adc_pkg::DONE_BIT] = s_q.flag;
          s_d.rdata[sar_adc_pkg::DIV_LSB +: sar_adc_pkg::DIV_W] = s_q.div;
        end else if (wb_adr_i == sar_adc_pkg::SEL_OFS) begin
          s_d.rdata[sar_adc_pkg::CH_LSB +: sar_adc_pkg::CH_W] = s_q.channel;
          s_d.rdata[sar_adc_pkg::LEFT_BIT] = s_q.left;
          s_d.rdata[sar_adc_pkg::REF_LSB +: sar_adc_pkg::REF_W] = s_q.reference;
        end else if (wb_adr_i == sar_adc_pkg::LOW_OFS) begin
          s_d.rdata[7:0] = res_low;
          s_d.lock = 1'b1;
        end else if (wb_adr_i == sar_adc_pkg::HIGH_OFS) begin
          s_d.rdata[7:0] = res_high;
          s_d.lock = 1'b0;
        end else if (wb_adr_i == sar_adc_pkg::STAT_OFS) begin
          s_d.rdata[sar_adc_pkg::BUSY_BIT] = (s_q.state == sar_adc_pkg::S_CONVERT);
          s_d.rdata[sar_adc_pkg::FIRST_BIT] = s_q.first;
          s_d.rdata[sar_adc_pkg::LOCK_BIT] = s_q.lock;
        end
      end
    end
    // sequencing runs on the converter clock; a disable write wins
    if (s_d.enable) begin
      if (s_q.state == sar_adc_pkg::S_CONVERT && fall && s_q.cyc == s_q.sample_at) begin
        s_d.sample = 1'b1;
      end
      if (rise) begin
        if (s_q.state == sar_adc_pkg::S_IDLE && s_q.start) begin
          s_d.state = sar_adc_pkg::S_CONVERT;
          s_d.cyc = '0;
          s_d.frozen = 1'b1;
          s_d.ext = s_q.first;
          if (s_q.first) begin
            s_d.len = sar_adc_pkg::EXT_LEN;
            s_d.sample_at = sar_adc_pkg::SAMPLE_EXT;
          end else if (conv_diff && half_rate) begin
            s_d.len = sar_adc_pkg::DIFF_LEN;
            s_d.sample_at = sar_adc_pkg::SAMPLE_DIFF;
          end else begin
            s_d.len = sar_adc_pkg::NORMAL_LEN;
            s_d.sample_at = sar_adc_pkg::SAMPLE_NORMAL;
          end
        end else if (s_q.state == sar_adc_pkg::S_CONVERT) begin
          s_d.cyc = s_q.cyc + 1'b1;
          if (s_d.cyc == s_q.len - 1'b1) begin
            s_d.frozen = 1'b0;
          end
          if (s_d.cyc == s_q.len) begin
            complete = 1'b1;
          end
        end
      end
    end
    if (complete) begin
      // set wins over a clear written in the same cycle
      s_d.flag = 1'b1;
      s_d.done = 1'b1;
      s_d.first = 1'b0;
      if (!s_q.lock) begin
        s_d.result = result_i;
      end
      if (s_d.free) begin
        // auto started: start stays high, flag state does not matter
        s_d.cyc = '0;
        s_d.frozen = 1'b1;
        s_d.ext = 1'b0;
        if (conv_diff) begin
          s_d.len = sar_adc_pkg::DIFF_LEN;
          s_d.sample_at = sar_adc_pkg::SAMPLE_DIFF;
        end else begin
          s_d.len = sar_adc_pkg::NORMAL_LEN;
          s_d.sample_at = sar_adc_pkg::SAMPLE_NORMAL;
        end
      end else begin
        s_d.state = sar_adc_pkg::S_IDLE;
        s_d.start = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.first <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign conversion_done_o = s_q.done;
  // one driver for the whole struct, fields in declaration order
  assign conv_o = {s_q.enable, channel_q, reference_q, bypass_q, s_q.sample};

  sequence seq_complete;
    s_q.done;
  endsequence

  sequence seq_launch;
    rise && s_q.enable && s_q.start && s_q.state == sar_adc_pkg::S_IDLE ##1
      s_q.state == sar_adc_pkg::S_CONVERT;
  endsequence

  a_flag_on_done: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_complete |-> s_q.flag)
    else $error("completion without flag");

  a_lock_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.lock |=> $stable(s_q.result))
    else $error("result changed while locked");

  a_high_unlocks: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_acc && !wb_we_i && wb_adr_i == sar_adc_pkg::HIGH_OFS |=> !s_q.lock)
    else $error("high read did not unlock");

  a_single_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_complete and s_q.state == sar_adc_pkg::S_IDLE |-> !s_q.start)
    else $error("start still set after single conversion");

  a_free_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_complete and s_q.state == sar_adc_pkg::S_CONVERT |-> s_q.start && s_q.cyc == '0)
    else $error("free running did not restart");

  a_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.enable [*2] |-> !rise && !fall && s_q.state == sar_adc_pkg::S_IDLE)
    else $error("activity while disabled");

  a_sample_point: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.sample |-> s_q.cyc == (s_q.ext ? sar_adc_pkg::SAMPLE_EXT :
      (s_q.len == sar_adc_pkg::DIFF_LEN ? sar_adc_pkg::SAMPLE_DIFF : sar_adc_pkg::SAMPLE_NORMAL)))
    else $error("sample at wrong cycle");

  a_conv_length: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_complete |-> $past(s_q.cyc) == $past(s_q.len) - 1'b1)
    else $error("conversion length wrong");

  a_start_on_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_launch |-> s_q.cyc == '0 && s_q.frozen && $past(rise))
    else $error("conversion not launched on converter rise");

  a_chan_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.frozen |=> $stable(channel_q) && $stable(reference_q))
    else $error("selection moved during conversion");

  a_busy_start: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.state == sar_adc_pkg::S_CONVERT |-> s_q.start)
    else $error("start low during a conversion");

  a_sample_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.sample |-> s_q.enable)
    else $error("sample pulse while disabled");

  a_done_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.done |-> s_q.enable)
    else $error("completion while disabled");

  a_result_on_done: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.done && !$past(s_q.lock) |-> s_q.result == $past(result_i))
    else $error("result not stored at completion");

  a_sample_once: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.sample |=> !s_q.sample)
    else $error("sample pulse longer than one cycle");

  a_half_held: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.enable |=> !half_rate)
    else $error("half rate clock running while disabled");

  a_reopen_last: assert property (@(posedge clk_i) disable iff (rst_i)
    rise && s_q.enable && s_q.state == sar_adc_pkg::S_CONVERT &&
      s_q.cyc + 1'b1 == s_q.len - 1'b1 |=> !s_q.frozen)
    else $error("selection buffer not reopened in last cycle");

  a_lock_on_low: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_acc && !wb_we_i && wb_adr_i == sar_adc_pkg::LOW_OFS |=> s_q.lock)
    else $error("low read did not lock");

  a_free_diff_len: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.done && s_q.state == sar_adc_pkg::S_CONVERT |->
      s_q.len == ($past(bypass_q) ? sar_adc_pkg::NORMAL_LEN : sar_adc_pkg::DIFF_LEN))
    else $error("wrong length for auto started conversion");

  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.flag && !(bus_acc && wb_we_i && wb_adr_i == sar_adc_pkg::CTRL_OFS &&
      wb_sel_i[0] && wb_dat_i[sar_adc_pkg::DONE_BIT]) |=> s_q.flag)
    else $error("completion flag lost without a clear");
endmodule // sar_adc_ctrl

//--- dv/analog_core_model.sv
// behavioural model of the multiplexer, gain stage and converter core
// assumes conv_i comes from the control block on the same clk_i
`timescale 1ns/1ps
module analog_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control from the block
  input wire sar_adc_pkg::conv_ctrl_s conv_i,
  // conversion result
  output logic [sar_adc_pkg::RES_W-1:0] result_o
);
  // the code encodes reference and channel seen at the sample pulse, so a selection change frozen out of conv_i does not show in the result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= 10'h000;
    end else if (conv_i.sample && conv_i.enable) begin
      result_o <= {conv_i.reference, conv_i.channel, 3'h5};
    end
  end
endmodule // analog_core_model

//--- dv/tb_sar_adc_conversion_control.sv
// self-checking bench for the converter control block
// assumes the analog core model answers from the sample pulse
`timescale 1ns/1ps
module tb_sar_adc_conversion_control;
  localparam int P = 4;
  localparam int LIMIT = 20000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic conversion_done_o;
  logic [sar_adc_pkg::RES_W-1:0] result;
  sar_adc_pkg::conv_ctrl_s conv;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n_done = 0;
  int last_t = 0;
  int prev_t = 0;
  int t0;

  always #10 clk_i = ~clk_i;

  sar_adc_ctrl dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .conv_o(conv), .result_i(result), .conversion_done_o(conversion_done_o)
  );

  analog_core_model core (
    .clk_i(clk_i), .rst_i(rst_i), .conv_i(conv), .result_o(result)
  );

  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_span(input string name, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // classic single cycle: request held until ack is sampled high, then released for a cycle
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (k >= 20) begin
      chk("ack", 32'h1, 32'h0);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, adr, wd, dummy);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, adr, 32'h0, got);
    chk(name, exp, got);
  endtask

  task automatic wait_done;
    int n;
    int k;
    n = n_done;
    k = 0;
    while (n_done == n && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 2000) begin
      chk("done_pulse", 32'h1, 32'h0);
    end
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (conversion_done_o === 1'b1) begin
      n_done <= n_done + 1;
      prev_t <= last_t;
      last_t <= cycles;
    end
    if (cycles == LIMIT) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("status", sar_adc_pkg::STAT_OFS, 32'h02);
    rd_chk("unmapped", 8'h14, 32'h0);
    wr(sar_adc_pkg::CTRL_OFS, 32'h42);
    rd_chk("ctrl_off", sar_adc_pkg::CTRL_OFS, 32'h02);
    wr(sar_adc_pkg::SEL_OFS, 32'h43);
    wr(sar_adc_pkg::CTRL_OFS, 32'h82);
    // the selection buffer loads one cycle after the enable lands
    @(posedge clk_i);
    chk("reference", 32'h1, {30'h0, conv.reference});
    chk("bypass", 32'h1, {31'h0, conv.gain_bypass});
    wr(sar_adc_pkg::CTRL_OFS, 32'hc2);
    t0 = cycles;
    rd_chk("ctrl_busy", sar_adc_pkg::CTRL_OFS, 32'hc2);
    wait_done();
    chk_span("ext_len", 25 * P, 26 * P + 3, last_t - t0);
    rd_chk("ctrl_done", sar_adc_pkg::CTRL_OFS, 32'h92);
    rd_chk("low_r", sar_adc_pkg::LOW_OFS, 32'h1d);
    rd_chk("high_r", sar_adc_pkg::HIGH_OFS, 32'h01);
    // normal conversion with a channel change while it runs
    wr(sar_adc_pkg::SEL_OFS, 32'h47);
    wr(sar_adc_pkg::CTRL_OFS, 32'hd2);
    t0 = cycles;
    // change only after the launch edge, a converter cycle after start
    repeat (P) @(posedge clk_i);
    wr(sar_adc_pkg::SEL_OFS, 32'h44);
    wait_done();
    chk_span("norm_len", 13 * P, 14 * P + 3, last_t - t0);
    rd_chk("low_old_ch", sar_adc_pkg::LOW_OFS, 32'h3d);
    rd_chk("high_old_ch", sar_adc_pkg::HIGH_OFS, 32'h01);
    wr(sar_adc_pkg::CTRL_OFS, 32'hd2);
    wait_done();
    rd_chk("low_new_ch", sar_adc_pkg::LOW_OFS, 32'h25);
    // the low read above locks the halves; the next result is dropped
    wr(sar_adc_pkg::SEL_OFS, 32'h86);
    wr(sar_adc_pkg::CTRL_OFS, 32'hd2);
    wait_done();
    rd_chk("flag_locked", sar_adc_pkg::CTRL_OFS, 32'h92);
    rd_chk("status_lock", sar_adc_pkg::STAT_OFS, 32'h04);
    rd_chk("high_locked", sar_adc_pkg::HIGH_OFS, 32'h01);
    rd_chk("low_locked", sar_adc_pkg::LOW_OFS, 32'h25);
    rd_chk("high_unlock", sar_adc_pkg::HIGH_OFS, 32'h01);
    wr(sar_adc_pkg::SEL_OFS, 32'ha6);
    wr(sar_adc_pkg::CTRL_OFS, 32'hd2);
    wait_done();
    rd_chk("low_left", sar_adc_pkg::LOW_OFS, 32'h40);
    rd_chk("high_left", sar_adc_pkg::HIGH_OFS, 32'h8d);
    // free running on a gain channel; the flag is left set on purpose
    wr(sar_adc_pkg::SEL_OFS, 32'h48);
    @(posedge clk_i);
    chk("bypass_diff", 32'h0, {31'h0, conv.gain_bypass});
    wr(sar_adc_pkg::CTRL_OFS, 32'hf2);
    wait_done();
    rd_chk("ctrl_free", sar_adc_pkg::CTRL_OFS, 32'hf2);
    wait_done();
    chk_span("auto_len", 14 * P, 14 * P, last_t - prev_t);
    wait_done();
    chk_span("auto_len2", 14 * P, 14 * P, last_t - prev_t);
    // disabling stops all activity and rearms the extended conversion
    wr(sar_adc_pkg::CTRL_OFS, 32'h00);
    t0 = n_done;
    repeat (200) @(posedge clk_i);
    chk_span("idle_done", t0, t0, n_done);
    chk("enable_out", 32'h0, {31'h0, conv.enable});
    rd_chk("status_off", sar_adc_pkg::STAT_OFS, 32'h02);
    wr(sar_adc_pkg::SEL_OFS, 32'h43);
    wr(sar_adc_pkg::CTRL_OFS, 32'h82);
    wr(sar_adc_pkg::CTRL_OFS, 32'hd2);
    t0 = cycles;
    wait_done();
    chk_span("ext_again", 25 * P, 26 * P + 3, last_t - t0);
    rd_chk("ctrl_single", sar_adc_pkg::CTRL_OFS, 32'h92);
    tally_and_finish();
  end
endmodule // tb_sar_adc_conversion_control
